// ===== logic/crs_ctrl.sv
// Purpose: Keyed reset request register and low-power entry control
// Assumes: AXI4-Lite slave, synchronous active-low reset, core status inputs synchronous
// Notes:   Sleep state machine tracks wait-for-event and sleep-on-exit entry
// What this block does
// - Writes with a wrong key are discarded entirely.
// - Keyed write with bit 2 set pulses a system reset request.
// - Wake-on-any-pending lets disabled interrupts also wake the core.
// - A newly pending event or interrupt raises the event signal when it wakes a sleeping core.
// - Events arriving while awake are latched for the next wait.
// - Send-event instruction or external event input also wakes the core.
// - Deep sleep select chooses ordinary sleep or deep sleep.
// - Sleep-on-exit enters sleep when a handler returns to thread mode.
module crs_ctrl
  import crs_pkg::*;
(
  input  wire logic        aclk,             // System clock
  input  wire logic        aresetn,          // Sync reset, active low
  input  wire logic [7:0]  s_axi_awaddr,     // Write address
  input  wire logic        s_axi_awvalid,    // Write address valid
  output logic             s_axi_awready,    // Write address ready
  input  wire logic [31:0] s_axi_wdata,      // Write data
  input  wire logic [3:0]  s_axi_wstrb,      // Byte strobes
  input  wire logic        s_axi_wvalid,     // Write data valid
  output logic             s_axi_wready,     // Write data ready
  output logic [1:0]       s_axi_bresp,      // Write response
  output logic             s_axi_bvalid,     // Write response valid
  input  wire logic        s_axi_bready,     // Write response ready
  input  wire logic [7:0]  s_axi_araddr,     // Read address
  input  wire logic        s_axi_arvalid,    // Read address valid
  output logic             s_axi_arready,    // Read address ready
  output logic [31:0]      s_axi_rdata,      // Read data
  output logic [1:0]       s_axi_rresp,      // Read response
  output logic             s_axi_rvalid,     // Read data valid
  input  wire logic        s_axi_rready,     // Read data ready
  input  wire logic        irq_pend_enabled, // Enabled interrupt pending
  input  wire logic        irq_pend_disabled,// Disabled interrupt pending
  input  wire logic        wait_for_event_instr, // Core executes wait-for-event
  input  wire logic        wait_for_irq_instr,   // Core executes wait-for-interrupt
  input  wire logic        send_event_instr, // Core executes send-event
  input  wire logic        ext_event_in,     // External event input
  input  wire logic        handler_exit_to_thread, // Return from handler to thread mode
  output logic             sys_reset_req,    // One-cycle system reset request
  output logic             core_event,       // Event pulse to core
  output logic             core_sleeping,    // Ordinary sleep active
  output logic             core_deep_sleep   // Deep sleep active
);

  // ==========================================================
  // Write decode helper
  // Key half-word must be fully strobed; a partial write cannot carry the key
  function automatic logic key_ok(input logic [31:0] d, input logic [3:0] s);
    key_ok = (d[31:KEY_LSB] == KEY_VALUE) && (s[3:2] == 2'b11);
  endfunction : key_ok

  // ==========================================================
  // State declarations
  logic        aw_held_r, aw_held_nxt;
  logic [7:0]  aw_addr_r, aw_addr_nxt;
  logic        w_held_r,  w_held_nxt;
  logic [31:0] w_data_r,  w_data_nxt;
  logic [3:0]  w_strb_r,  w_strb_nxt;
  logic        bvalid_r,  bvalid_nxt;
  logic [1:0]  bresp_r,   bresp_nxt;
  logic        rvalid_r,  rvalid_nxt;
  logic [31:0] rdata_r,   rdata_nxt;
  logic [1:0]  rresp_r,   rresp_nxt;
  logic        wake_any_r, wake_any_nxt;
  logic        deep_r,    deep_nxt;
  logic        soexit_r,  soexit_nxt;
  logic        rst_req_r, rst_req_nxt;
  logic        ev_latch_r, ev_latch_nxt;
  logic        event_r,   event_nxt;
  logic        pend_prev_r, pend_prev_nxt;
  crs_pstate_t pstate_r,  pstate_nxt;
  // Registered copies that feed the ports directly
  logic        awready_r, awready_nxt;
  logic        wready_r,  wready_nxt;
  logic        arready_r, arready_nxt;
  logic        sleep_r,   sleep_nxt;
  logic        dsleep_r,  dsleep_nxt;
  logic        wr_fire;
  logic        pend_now;
  logic        ev_src;
  logic        wake;

  // ==========================================================
  // Wake sources
  assign pend_now = irq_pend_enabled | (wake_any_r & irq_pend_disabled);
  assign ev_src   = (pend_now & ~pend_prev_r) | send_event_instr | ext_event_in;
  assign wake     = ev_src | irq_pend_enabled | (wake_any_r & irq_pend_disabled);
  // Both halves held and no response pending; aw and w may come in any order
  assign wr_fire  = aw_held_r & w_held_r & ~bvalid_r;

  // ==========================================================
  // Bus write channel and control registers, next state
  always_comb begin
    aw_held_nxt  = aw_held_r;
    aw_addr_nxt  = aw_addr_r;
    w_held_nxt   = w_held_r;
    w_data_nxt   = w_data_r;
    w_strb_nxt   = w_strb_r;
    bvalid_nxt   = bvalid_r;
    bresp_nxt    = bresp_r;
    wake_any_nxt = wake_any_r;
    deep_nxt     = deep_r;
    soexit_nxt   = soexit_r;
    rst_req_nxt  = 1'b0;
    if (s_axi_awvalid && !aw_held_r) begin
      aw_held_nxt = 1'b1;
      aw_addr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_held_r) begin
      w_held_nxt = 1'b1;
      w_data_nxt = s_axi_wdata;
      w_strb_nxt = s_axi_wstrb;
    end
    if (wr_fire) begin
      aw_held_nxt = 1'b0;
      w_held_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = RESP_OKAY;
      case (aw_addr_r)
        OFS_AIRC: begin
          // Key judged on this write alone; nothing unlocks later writes
          if (key_ok(w_data_r, w_strb_r) && w_strb_r[0]) begin
            rst_req_nxt = w_data_r[BIT_SYSRST];
          end
        end
        OFS_LPEC: begin
          if (w_strb_r[0]) begin
            wake_any_nxt = w_data_r[BIT_WAKEANY];
            deep_nxt     = w_data_r[BIT_DEEP];
            soexit_nxt   = w_data_r[BIT_SOEXIT];
          end
        end
        OFS_PWR_STATUS: bresp_nxt = RESP_OKAY;  // Read-only, write ignored
        default:        bresp_nxt = RESP_SLVERR;
      endcase
    end
    // Response stands until the master takes it
    if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
    // Ready tracks the free holding slot, registered so the port is a flop
    awready_nxt = ~aw_held_nxt;
    wready_nxt  = ~w_held_nxt;
  end

  // ==========================================================
  // Bus read channel, next state
  always_comb begin
    rvalid_nxt = rvalid_r;
    rdata_nxt  = rdata_r;
    rresp_nxt  = rresp_r;
    if (s_axi_arvalid && !rvalid_r) begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = RESP_OKAY;
      rdata_nxt  = 32'h0000_0000;
      case (s_axi_araddr)
        OFS_AIRC: rdata_nxt[31:KEY_LSB] = KEY_READBACK;  // Control bits read as zero
        OFS_LPEC: begin
          rdata_nxt[BIT_WAKEANY] = wake_any_r;
          rdata_nxt[BIT_DEEP]    = deep_r;
          rdata_nxt[BIT_SOEXIT]  = soexit_r;
        end
        OFS_PWR_STATUS: rdata_nxt[3:0] = {ev_latch_r, pstate_r};
        default:  rresp_nxt = RESP_SLVERR;
      endcase
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
    // A new read address is taken only once the last answer is gone;
    // this keeps a single read in flight without any queue
    arready_nxt = ~rvalid_nxt;
  end

  // ==========================================================
  // Event latch and power state machine, next state
  always_comb begin
    pend_prev_nxt = pend_now;
    event_nxt     = 1'b0;
    ev_latch_nxt  = ev_latch_r;
    pstate_nxt    = pstate_r;
    case (pstate_r)
      ST_RUN: begin
        if (ev_src) begin
          ev_latch_nxt = 1'b1;
        end
        if (wait_for_event_instr) begin
          // A latched event lets the wait fall straight through
          if (ev_latch_r || ev_src) begin
            ev_latch_nxt = 1'b0;
          end else begin
            pstate_nxt = deep_r ? ST_DEEP : ST_SLEEP;
          end
        end else if (wait_for_irq_instr || (handler_exit_to_thread && soexit_r)) begin
          pstate_nxt = deep_r ? ST_DEEP : ST_SLEEP;
        end
      end
      ST_SLEEP, ST_DEEP: begin
        if (wake) begin
          event_nxt    = ev_src;
          ev_latch_nxt = 1'b0;
          pstate_nxt   = ST_RUN;
        end
      end
      default: pstate_nxt = ST_RUN;
    endcase
    // Decoded here so the state outputs leave straight from flops
    sleep_nxt  = (pstate_nxt == ST_SLEEP);
    dsleep_nxt = (pstate_nxt == ST_DEEP);
  end

  // ==========================================================
  // Bus write channel and control registers
  // Control bits clear on reset; software rewrites them after any system reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r  <= RST_BIT;
      aw_addr_r  <= RST_ADDR;
      w_held_r   <= RST_BIT;
      w_data_r   <= RST_WORD;
      w_strb_r   <= RST_STRB;
      bvalid_r   <= RST_BIT;
      bresp_r    <= RESP_OKAY;
      wake_any_r <= RST_BIT;
      deep_r     <= RST_BIT;
      soexit_r   <= RST_BIT;
      rst_req_r  <= RST_BIT;
      awready_r  <= RST_READY;
      wready_r   <= RST_READY;
    end else begin
      aw_held_r  <= aw_held_nxt;
      aw_addr_r  <= aw_addr_nxt;
      w_held_r   <= w_held_nxt;
      w_data_r   <= w_data_nxt;
      w_strb_r   <= w_strb_nxt;
      bvalid_r   <= bvalid_nxt;
      bresp_r    <= bresp_nxt;
      wake_any_r <= wake_any_nxt;
      deep_r     <= deep_nxt;
      soexit_r   <= soexit_nxt;
      rst_req_r  <= rst_req_nxt;
      awready_r  <= awready_nxt;
      wready_r   <= wready_nxt;
    end
  end

  // ==========================================================
  // Bus read channel registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r  <= RST_BIT;
      rdata_r   <= RST_WORD;
      rresp_r   <= RESP_OKAY;
      arready_r <= RST_READY;
    end else begin
      rvalid_r  <= rvalid_nxt;
      rdata_r   <= rdata_nxt;
      rresp_r   <= rresp_nxt;
      arready_r <= arready_nxt;
    end
  end

  // ==========================================================
  // Event latch and power state registers
  // Power state restarts in run so the core never wakes into a stale sleep
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ev_latch_r  <= RST_BIT;
      event_r     <= RST_BIT;
      pend_prev_r <= RST_BIT;
      pstate_r    <= ST_RUN;
      sleep_r     <= RST_BIT;
      dsleep_r    <= RST_BIT;
    end else begin
      ev_latch_r  <= ev_latch_nxt;
      event_r     <= event_nxt;
      pend_prev_r <= pend_prev_nxt;
      pstate_r    <= pstate_nxt;
      sleep_r     <= sleep_nxt;
      dsleep_r    <= dsleep_nxt;
    end
  end

  // ==========================================================
  // Outputs, all straight from flip-flops
  assign s_axi_awready   = awready_r;
  assign s_axi_wready    = wready_r;
  assign s_axi_bvalid    = bvalid_r;
  assign s_axi_bresp     = bresp_r;
  assign s_axi_arready   = arready_r;
  assign s_axi_rvalid    = rvalid_r;
  assign s_axi_rdata     = rdata_r;
  assign s_axi_rresp     = rresp_r;
  assign sys_reset_req   = rst_req_r;
  assign core_event      = event_r;
  assign core_sleeping   = sleep_r;
  assign core_deep_sleep = dsleep_r;

endmodule : crs_ctrl

// ===== logic/crs_pkg.sv
// Purpose: Constants for the reset and low-power control register bank
// Assumes: 32-bit AXI4-Lite register access, byte offsets
// Notes:   One aligned word per register
package crs_pkg;
  // ==========================================================
  // Register offsets
  localparam logic [7:0]  OFS_AIRC       = 8'h0C;   // app_interrupt_reset_control
  localparam logic [7:0]  OFS_LPEC       = 8'h10;   // low_power_entry_control
  localparam logic [7:0]  OFS_PWR_STATUS = 8'h14;   // Sleep/event status, read only
  // ==========================================================
  // Field positions
  localparam int          KEY_LSB        = 16;
  localparam logic [15:0] KEY_VALUE      = 16'h05FA;
  localparam logic [15:0] KEY_READBACK   = 16'hFA05;
  localparam int          BIT_SYSRST     = 2;
  localparam int          BIT_CLRACT     = 1;
  localparam int          BIT_WAKEANY    = 4;
  localparam int          BIT_DEEP       = 2;
  localparam int          BIT_SOEXIT     = 1;
  // ==========================================================
  // Reset values
  localparam logic        RST_BIT        = 1'b0;
  localparam logic        RST_READY      = 1'b1;    // Ready lines idle high
  localparam logic [7:0]  RST_ADDR       = 8'h00;
  localparam logic [31:0] RST_WORD       = 32'h0000_0000;
  localparam logic [3:0]  RST_STRB       = 4'h0;
  localparam logic [1:0]  RESP_OKAY      = 2'b00;
  localparam logic [1:0]  RESP_SLVERR    = 2'b10;
  // ==========================================================
  // Core power states
  typedef enum logic [2:0] {
    ST_RUN   = 3'b001,
    ST_SLEEP = 3'b010,
    ST_DEEP  = 3'b100
  } crs_pstate_t;
endpackage : crs_pkg

// ===== tb/crs_ctrl_asserts.sv
// Purpose: Port checks for crs_ctrl
// Assumes: One clock, sync active-low reset
// Notes:   Bound to every crs_ctrl instance
// ==========================================
// Checker
module crs_ctrl_asserts
  import crs_pkg::*;
(
  input wire logic        aclk,             // Clock
  input wire logic        aresetn,          // Reset, active low
  input wire logic [31:0] s_axi_wdata,      // Write data
  input wire logic        s_axi_wvalid,     // Write data valid
  input wire logic        s_axi_wready,     // Write data ready
  input wire logic        s_axi_bvalid,     // Write response valid
  input wire logic        irq_pend_enabled, // Enabled pending
  input wire logic        send_event_instr, // Send-event
  input wire logic        ext_event_in,     // External event
  input wire logic        sys_reset_req,    // Reset request
  input wire logic        core_event,       // Event pulse
  input wire logic        core_sleeping,    // Sleep
  input wire logic        core_deep_sleep   // Deep sleep
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] wd_r; // Last accepted write word
  logic        sl;   // Either low-power state
  assign sl = core_sleeping || core_deep_sleep;
  // Capture write word; one write at a time keeps it unambiguous
  always_ff @(posedge aclk) begin
    if (s_axi_wvalid && s_axi_wready) begin
      wd_r <= s_axi_wdata;
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_awake_soon;
    ##[1:2] !(core_sleeping || core_deep_sleep);
  endsequence
  chk_rst_one_cycle: assert property (sys_reset_req |=> !sys_reset_req)
    else $error("reset request longer than one cycle");
  chk_rst_with_resp: assert property (sys_reset_req |-> s_axi_bvalid)
    else $error("reset request without write response");
  chk_rst_key_ok: assert property (sys_reset_req |-> wd_r[31:16] == KEY_VALUE && wd_r[BIT_SYSRST])
    else $error("reset request without keyed write");
  chk_evt_one_cycle: assert property (core_event |=> !core_event)
    else $error("event pulse longer than one cycle");
  chk_state_onehot: assert property (!(core_sleeping && core_deep_sleep))
    else $error("both sleep states active");
  chk_pend_wake: assert property ((sl && irq_pend_enabled) |-> s_awake_soon)
    else $error("enabled pending did not wake");
  chk_sev_wake: assert property ((sl && send_event_instr) |-> s_awake_soon)
    else $error("send-event did not wake");
  chk_ext_wake: assert property ((sl && ext_event_in) |-> s_awake_soon)
    else $error("external event did not wake");
endmodule : crs_ctrl_asserts

bind crs_ctrl crs_ctrl_asserts chk_u (.aclk, .aresetn, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .irq_pend_enabled, .send_event_instr, .ext_event_in, .sys_reset_req, .core_event,
  .core_sleeping, .core_deep_sleep);

// ===== tb/crs_ctrl_tb.sv
// Purpose: Register and sleep tests for crs_ctrl
// Assumes: AXI4-Lite master, ready lines held high
// Notes:   Core instruction strobes are one-cycle pulses
// ==========================================
// Bench
module crs_ctrl_tb
  import crs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, irq_pend_enabled, irq_pend_disabled;
  logic sys_reset_req, core_event, core_sleeping, core_deep_sleep;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [4:0]  ins; // Wait evt, send evt, ext evt, exit, wait irq
  int err_total, n_compared, rst_cnt, evt_cnt;
  crs_ctrl dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .irq_pend_enabled, .irq_pend_disabled, .wait_for_event_instr(ins[0]),
    .send_event_instr(ins[1]), .ext_event_in(ins[2]), .handler_exit_to_thread(ins[3]),
    .wait_for_irq_instr(ins[4]), .sys_reset_req, .core_event, .core_sleeping, .core_deep_sleep);
  // Clock, 10 ns period
  initial begin
    aclk = 1'h0;
    forever #5 aclk = ~aclk;
  end
  // Count output pulses as seen at each edge
  always @(posedge aclk) begin
    if (sys_reset_req === 1'h1) rst_cnt <= rst_cnt + 1;
    if (core_event === 1'h1) evt_cnt <= evt_cnt + 1;
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // Write; settles two edges so pulse counters catch up
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] rs);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    chk(32'({s_axi_bvalid, s_axi_bresp}), 32'({1'h1, rs}));
    repeat (2) @(posedge aclk);
  endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] rs);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    chk(32'({s_axi_rvalid, s_axi_rresp}), 32'({1'h1, rs}));
    chk(s_axi_rdata, e);
  endtask : rd
  // One-cycle core pulse, then time to settle
  task pulse(input int k);
    ins <= 5'(1 << k);
    @(posedge aclk);
    ins <= 5'h00;
    repeat (2) @(posedge aclk);
  endtask : pulse
  task st(input logic s, input logic dp);
    chk(32'({core_sleeping, core_deep_sleep}), 32'({s, dp}));
  endtask : st
  task final_report;
    $display("compared %0d errors %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : final_report
  // Watchdog, far beyond the roughly 120 cycles needed
  initial begin
    #50000;
    err_total++;
    final_report;
  end
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, irq_pend_enabled, irq_pend_disabled} <= 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= 48'h0;
    {s_axi_bready, s_axi_rready, s_axi_wstrb, ins} <= 11'h7E0;
    aresetn <= 1'h0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    rd(OFS_AIRC, {KEY_READBACK, 16'h0000}, RESP_OKAY);
    rd(OFS_LPEC, 32'h00000000, RESP_OKAY);
    rd(OFS_PWR_STATUS, 32'h00000001, RESP_OKAY);
    rd(8'h40, 32'h00000000, RESP_SLVERR);
    wr(8'h40, 32'h00000000, RESP_SLVERR);
    wr(OFS_AIRC, 32'h12340004, RESP_OKAY);
    chk(32'(rst_cnt), 32'h0);
    wr(OFS_AIRC, {KEY_VALUE, 16'h0004}, RESP_OKAY);
    chk(32'(rst_cnt), 32'h1);
    wr(OFS_AIRC, 32'h05FB0004, RESP_OKAY);
    chk(32'(rst_cnt), 32'h1);
    wr(OFS_AIRC, {KEY_VALUE, 16'h0000}, RESP_OKAY);
    chk(32'(rst_cnt), 32'h1);
    rd(OFS_AIRC, {KEY_READBACK, 16'h0000}, RESP_OKAY);
    wr(OFS_LPEC, 32'hFFFFFFFF, RESP_OKAY);
    rd(OFS_LPEC, 32'h00000016, RESP_OKAY);
    // Ordinary sleep, woken by send-event
    wr(OFS_LPEC, 32'h00000000, RESP_OKAY);
    pulse(0);
    st(1'h1, 1'h0);
    pulse(1);
    st(1'h0, 1'h0);
    chk(32'(evt_cnt), 32'h1);
    // Event while awake is latched and eats the next wait
    pulse(2);
    rd(OFS_PWR_STATUS, 32'h00000009, RESP_OKAY);
    pulse(0);
    st(1'h0, 1'h0);
    // With wake-any clear, deep sleep ignores disabled pending; with wake-any set, disabled pending wakes ordinary sleep
    wr(OFS_LPEC, 32'h00000004, RESP_OKAY);
    pulse(0);
    st(1'h0, 1'h1);
    irq_pend_disabled <= 1'h1;
    repeat (3) @(posedge aclk);
    st(1'h0, 1'h1);
    chk(32'(evt_cnt), 32'h1);
    irq_pend_enabled <= 1'h1;
    repeat (3) @(posedge aclk);
    st(1'h0, 1'h0);
    {irq_pend_enabled, irq_pend_disabled} <= 2'h0;
    wr(OFS_LPEC, 32'h00000010, RESP_OKAY);
    pulse(0);
    st(1'h1, 1'h0);
    irq_pend_disabled <= 1'h1;
    repeat (3) @(posedge aclk);
    st(1'h0, 1'h0);
    irq_pend_disabled <= 1'h0;
    // Sleep on handler exit, woken by external event
    wr(OFS_LPEC, 32'h00000002, RESP_OKAY);
    pulse(3);
    st(1'h1, 1'h0);
    pulse(2);
    st(1'h0, 1'h0);
    wr(OFS_LPEC, 32'h00000000, RESP_OKAY);
    pulse(3);
    st(1'h0, 1'h0);
    // Wait-for-interrupt sleeps even with an event latched
    pulse(2);
    pulse(4);
    st(1'h1, 1'h0);
    pulse(1);
    st(1'h0, 1'h0);
    chk(32'(evt_cnt), 32'h5);
    final_report;
  end
endmodule : crs_ctrl_tb
